// *** logic/ramp_ctrl.sv ***
// Purpose: ramp generator control behind the 3-wire serial registers
// Assumes: pins and reference are asynchronous; link clock far below clk
// Notes: serial word shifts msb first, latched on load strobe rise
`timescale 1ns/1ns
`include "ramp_regs.svh"
module ramp_ctrl
	import ramp_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// serial link
	input wire logic serial_clk_pin,
	input wire logic serial_data_pin,
	input wire logic serial_load_strobe,
	// reference and modulation
	input wire logic phase_comparator_ref,
	input wire logic modulation_input_pin,
	// outputs
	output logic multiplexed_output_pin,
	output nval_t divider_value,
	output logic fast_lock,
	output logic ramp_active
);
	localparam int S_SCK = 0;
	localparam int S_DAT = 1;
	localparam int S_LE = 2;
	localparam int S_REF = 3;
	localparam int S_MOD = 4;

	logic [4:0] sync1_reg;
	logic [4:0] sync2_reg;
	logic [4:0] prev_reg;
	logic sck_rise, le_rise, ref_tick, mod_rise;
	logic [31:0] shift_reg;
	logic [`ADDR_HI:0] addr;
	logic wr_stb, start_stb;

	// configuration
	logic [31:0] div_reg;
	logic [12:0] frac_lsb_reg;
	logic [11:0] clk_a_reg, clk_b_reg;
	logic [1:0] type_reg;
	logic cnt_rst_reg;
	logic [4:0] test_mux_reg;
	logic [15:0] dev_word_reg [2];
	logic [3:0] dev_exp_reg [2];
	logic [19:0] steps_reg [2];
	logic dual_reg, fsk_reg, para_reg, ext_reg;
	logic [1:0] irq_mode_reg;
	logic [11:0] dly_word_reg;
	logic dly_start_reg, dly_long_reg, dly_gap_reg, dly_fast_reg;

	// ramp engine
	ramp_state_t state_reg;
	nval_t base_reg, base_next, nval_reg, n_out_reg, nval_step;
	nval_t dev_ext, fsk_ext, idx1, delta;
	logic [19:0] idx_reg;
	logic set_reg, dir_reg, fsk_phase_reg, done_reg, gap_first_reg;
	logic step_tick, dly_tick, step_ev, irq_ev, burst_end, run_step_ev;
	nval_t rb_reg, cap_reg;
	logic [5:0] rb_cnt_reg;
	logic mux_reg, fast_reg;

	tick_if step_t ();
	tick_if dly_t ();

	// two-stage synchronisers, third stage only for edges
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
			prev_reg <= '0;
		end else begin
			sync1_reg <= {modulation_input_pin, phase_comparator_ref,
				serial_load_strobe, serial_data_pin, serial_clk_pin};
			sync2_reg <= sync1_reg;
			prev_reg <= sync2_reg;
		end
	end

	assign sck_rise = sync2_reg[S_SCK] && !prev_reg[S_SCK];
	assign le_rise = sync2_reg[S_LE] && !prev_reg[S_LE];
	assign ref_tick = sync2_reg[S_REF] && !prev_reg[S_REF];
	assign mod_rise = sync2_reg[S_MOD] && !prev_reg[S_MOD];

	// serial word assembly
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			shift_reg <= '0;
		else if (sck_rise)
			shift_reg <= {shift_reg[30:0], sync2_reg[S_DAT]};
	end

	assign wr_stb = le_rise;
	assign addr = shift_reg[`ADDR_HI:0];
	assign start_stb = wr_stb && addr == `ADDR_DIVIDER &&
		shift_reg[`DIV_START];
	assign base_next = {shift_reg[`DIV_INT_HI:`DIV_INT_LO],
		shift_reg[`DIV_FRAC_HI:`DIV_FRAC_LO], frac_lsb_reg};

	// register file, writable at any time
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			div_reg <= '0;
			frac_lsb_reg <= '0;
			clk_a_reg <= `RST_CLK;
			clk_b_reg <= `RST_CLK;
			type_reg <= `TYPE_SAW;
			cnt_rst_reg <= 1'b0;
			test_mux_reg <= '0;
			for (int i = 0; i < 2; i++) begin
				dev_word_reg[i] <= '0;
				dev_exp_reg[i] <= '0;
				steps_reg[i] <= '0;
			end
			{dual_reg, fsk_reg, para_reg, ext_reg} <= '0;
			irq_mode_reg <= `IRQ_OFF;
			dly_word_reg <= '0;
			{dly_start_reg, dly_long_reg, dly_gap_reg, dly_fast_reg} <= '0;
		end else if (wr_stb) begin
			case (addr)
			`ADDR_DIVIDER: div_reg <= shift_reg;
			`ADDR_FRAC_LSB: frac_lsb_reg <= shift_reg[`FRACL_HI:`FRACL_LO];
			`ADDR_RDIV: clk_a_reg <= shift_reg[`RDIV_CLKA_HI:`RDIV_CLKA_LO];
			`ADDR_FUNCTION: begin
				type_reg <= shift_reg[`FUNC_TYPE_HI:`FUNC_TYPE_LO];
				cnt_rst_reg <= shift_reg[`FUNC_CNT_RST];
			end
			`ADDR_TEST: begin
				test_mux_reg <= shift_reg[`TEST_MUX_HI:`TEST_MUX_LO];
				clk_b_reg <= shift_reg[`TEST_CLKB_HI:`TEST_CLKB_LO];
			end
			`ADDR_DEVIATION: begin
				dev_word_reg[shift_reg[`SET_SEL]] <=
					shift_reg[`DEV_WORD_HI:`DEV_WORD_LO];
				dev_exp_reg[shift_reg[`SET_SEL]] <=
					shift_reg[`DEV_EXP_HI:`DEV_EXP_LO];
				dual_reg <= shift_reg[`DEV_DUAL];
				fsk_reg <= shift_reg[`DEV_FSK];
				irq_mode_reg <= shift_reg[`DEV_IRQ_HI:`DEV_IRQ_LO];
				para_reg <= shift_reg[`DEV_PARA];
				ext_reg <= shift_reg[`DEV_EXT];
			end
			`ADDR_STEP: steps_reg[shift_reg[`SET_SEL]] <=
				shift_reg[`STEP_HI:`STEP_LO];
			`ADDR_DELAY: begin
				dly_word_reg <= shift_reg[`DLY_HI:`DLY_LO];
				dly_start_reg <= shift_reg[`DLY_START];
				dly_long_reg <= shift_reg[`DLY_LONG];
				dly_gap_reg <= shift_reg[`DLY_GAP];
				dly_fast_reg <= shift_reg[`DLY_FAST];
			end
			default: ;
			endcase
		end
	end

	// timers: step interval and start or gap delay
	assign step_t.ref_tick = ref_tick;
	assign step_t.restart = !(state_reg == RS_RUN || state_reg == RS_WRAP);
	assign step_t.count_a = clk_a_reg;
	assign step_t.count_b = clk_b_reg;
	assign step_tick = step_t.tick;
	assign dly_t.ref_tick = ref_tick;
	assign dly_t.restart = !(state_reg == RS_START_DLY ||
		state_reg == RS_GAP_DLY);
	assign dly_t.count_a = dly_word_reg;
	assign dly_t.count_b = dly_long_reg ? clk_a_reg : `ONE_12;
	assign dly_tick = dly_t.tick;

	interval_timer #(.W(12)) step_timer_u (
		.clk(clk),
		.rst_b(rst_b),
		.t(step_t)
	);
	interval_timer #(.W(12)) delay_timer_u (
		.clk(clk),
		.rst_b(rst_b),
		.t(dly_t)
	);

	// step arithmetic
	assign step_ev = ext_reg ? mod_rise : step_tick;
	assign irq_ev = mod_rise && irq_mode_reg != `IRQ_OFF;
	assign dev_ext = {{21{dev_word_reg[set_reg][15]}},
		dev_word_reg[set_reg]} << dev_exp_reg[set_reg];
	assign fsk_ext = {{21{dev_word_reg[1][15]}}, dev_word_reg[1]} <<
		dev_exp_reg[1];
	assign idx1 = {17'h0_0000, idx_reg} + 37'h0_0000_0001;
	assign delta = para_reg ? dev_ext * idx1 : dev_ext;
	assign nval_step = dir_reg ? nval_reg - delta : nval_reg + delta;
	assign burst_end = idx_reg + 20'h0_0001 >= steps_reg[set_reg];
	assign run_step_ev = state_reg == RS_RUN && step_ev;

	// ramp sequencing
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_reg <= RS_IDLE;
			base_reg <= '0;
			nval_reg <= '0;
			idx_reg <= '0;
			set_reg <= 1'b0;
			dir_reg <= 1'b0;
		end else if (cnt_rst_reg) begin
			state_reg <= RS_IDLE;
			idx_reg <= '0;
			set_reg <= 1'b0;
			dir_reg <= 1'b0;
		end else if (start_stb) begin
			base_reg <= base_next;
			nval_reg <= base_next;
			idx_reg <= '0;
			set_reg <= 1'b0;
			dir_reg <= 1'b0;
			state_reg <= dly_start_reg ? RS_START_DLY : RS_RUN;
		end else if (irq_ev && irq_mode_reg == `IRQ_STOP) begin
			state_reg <= RS_HOLD;
		end else begin
			case (state_reg)
			RS_START_DLY, RS_GAP_DLY: begin
				if (dly_tick)
					state_reg <= RS_RUN;
			end
			RS_RUN: begin
				if (step_ev) begin
					nval_reg <= nval_step;
					idx_reg <= burst_end ? '0 : idx_reg + 20'h0_0001;
					if (burst_end) begin
						case (type_reg)
						`TYPE_TRI: begin
							dir_reg <= !dir_reg;
							set_reg <= dual_reg ? !set_reg : 1'b0;
							state_reg <= dly_gap_reg ? RS_GAP_DLY : RS_RUN;
						end
						`TYPE_SRAMP: state_reg <= RS_HOLD;
						default: state_reg <= RS_WRAP;
						endcase
					end
				end
			end
			RS_WRAP: begin
				if (step_ev) begin
					nval_reg <= base_reg;
					set_reg <= dual_reg ? !set_reg : 1'b0;
					if (type_reg == `TYPE_SSAW)
						state_reg <= RS_HOLD;
					else
						state_reg <= dly_gap_reg ? RS_GAP_DLY : RS_RUN;
				end
			end
			RS_IDLE, RS_HOLD: ;
			default: state_reg <= RS_IDLE;
			endcase
		end
	end

	// shift offset on top of the ramp, alternating per step
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			fsk_phase_reg <= 1'b0;
			n_out_reg <= '0;
		end else begin
			if (start_stb)
				fsk_phase_reg <= 1'b0;
			else if (run_step_ev)
				fsk_phase_reg <= !fsk_phase_reg;
			n_out_reg <= nval_reg + ((fsk_reg && fsk_phase_reg) ?
				fsk_ext : '0);
		end
	end

	// ramp complete flag, setting wins over clearing
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			done_reg <= 1'b0;
		else if (run_step_ev && burst_end)
			done_reg <= 1'b1;
		else if (start_stb)
			done_reg <= 1'b0;
	end

	// readback capture and shift
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rb_reg <= '0;
			cap_reg <= '0;
			rb_cnt_reg <= '0;
		end else if (irq_ev) begin
			rb_reg <= n_out_reg;
			cap_reg <= n_out_reg;
			rb_cnt_reg <= `RB_BITS;
		end else if (sck_rise && rb_cnt_reg != '0) begin
			rb_reg <= {rb_reg[35:0], 1'b0};
			rb_cnt_reg <= rb_cnt_reg - 6'h01;
		end else if (wr_stb) begin
			// a write frame clocks the word away; restart from the capture
			rb_reg <= cap_reg;
			rb_cnt_reg <= `RB_BITS;
		end
	end

	// output pin selection and fast lock window
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			mux_reg <= 1'b0;
		end else if (div_reg[`DIV_MUX_HI:`DIV_MUX_LO] != `MUX_RAMP) begin
			mux_reg <= 1'b0;
		end else if (test_mux_reg == `TEST_DONE) begin
			mux_reg <= done_reg;
		end else if (test_mux_reg[`TEST_RB_HI-`TEST_MUX_LO:0] == `TEST_RB) begin
			mux_reg <= rb_reg[36];
		end else begin
			mux_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			gap_first_reg <= 1'b0;
			fast_reg <= 1'b0;
		end else begin
			if (state_reg != RS_GAP_DLY)
				gap_first_reg <= 1'b1;
			else if (ref_tick)
				gap_first_reg <= 1'b0;
			fast_reg <= state_reg == RS_GAP_DLY && gap_first_reg &&
				dly_fast_reg;
		end
	end

	assign multiplexed_output_pin = mux_reg;
	assign divider_value = n_out_reg;
	assign fast_lock = fast_reg;
	assign ramp_active = state_reg != RS_IDLE && state_reg != RS_HOLD;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	sequence idle_no_start;
		state_reg == RS_IDLE && !start_stb;
	endsequence
	sequence run_step_up;
		run_step_ev && !cnt_rst_reg && !start_stb && !dir_reg && !irq_ev;
	endsequence

	start_gate_a: assert property (idle_no_start |=>
		state_reg != RS_RUN)
		else $error("ramp ran without start write");
	delayed_start_a: assert property (start_stb && dly_start_reg &&
		!cnt_rst_reg |=> state_reg == RS_START_DLY)
		else $error("start delay skipped");
	para_step_a: assert property (run_step_up ##0 para_reg |=>
		nval_reg == $past(nval_reg) + $past(dev_ext) * $past(idx1))
		else $error("parabolic increment wrong");
	ext_hold_a: assert property (state_reg == RS_RUN && ext_reg &&
		!mod_rise && !start_stb && !cnt_rst_reg |=> $stable(nval_reg))
		else $error("step without modulation pulse");
	irq_stop_a: assert property (irq_ev && irq_mode_reg == `IRQ_STOP &&
		!start_stb && !cnt_rst_reg |=> state_reg == RS_HOLD [*2])
		else $error("sweep did not stop");
	capture_a: assert property (irq_ev |=>
		rb_reg == $past(n_out_reg) && rb_cnt_reg == `RB_BITS)
		else $error("readback capture wrong");
	rb_shift_a: assert property (sck_rise && !irq_ev &&
		rb_cnt_reg != '0 |=> rb_reg == {$past(rb_reg[35:0]), 1'b0})
		else $error("readback shift wrong");
	done_pin_a: assert property (div_reg[`DIV_MUX_HI:`DIV_MUX_LO] ==
		`MUX_RAMP && test_mux_reg == `TEST_DONE |=>
		multiplexed_output_pin == $past(done_reg))
		else $error("ramp complete not on pin");
	dev_select_a: assert property (wr_stb && addr == `ADDR_DEVIATION |=>
		dev_word_reg[$past(shift_reg[`SET_SEL])] ==
		$past(shift_reg[`DEV_WORD_HI:`DEV_WORD_LO]))
		else $error("deviation set not loaded");
	fast_gap_a: assert property (fast_lock |->
		$past(state_reg) == RS_GAP_DLY && dly_fast_reg)
		else $error("fast lock outside gap");
endmodule // ramp_ctrl

// *** inc/ramp_regs.svh ***
// Purpose: field positions, codes and reset values of the ramp controller
// Assumes: 32-bit serial words, register index in bits 2..0
// Notes: used by the ramp controller only; its interval timer uses none of it
`ifndef RAMP_REGS_SVH
`define RAMP_REGS_SVH
`define ADDR_HI 2
`define ADDR_DIVIDER 3'h0
`define ADDR_FRAC_LSB 3'h1
`define ADDR_RDIV 3'h2
`define ADDR_FUNCTION 3'h3
`define ADDR_TEST 3'h4
`define ADDR_DEVIATION 3'h5
`define ADDR_STEP 3'h6
`define ADDR_DELAY 3'h7
`define DIV_START 31
`define DIV_MUX_HI 30
`define DIV_MUX_LO 27
`define DIV_INT_HI 26
`define DIV_INT_LO 15
`define DIV_FRAC_HI 14
`define DIV_FRAC_LO 3
`define FRACL_HI 27
`define FRACL_LO 15
`define RDIV_CLKA_HI 14
`define RDIV_CLKA_LO 3
`define FUNC_TYPE_HI 11
`define FUNC_TYPE_LO 10
`define FUNC_CNT_RST 3
`define TEST_MUX_HI 25
`define TEST_MUX_LO 21
`define TEST_RB_HI 22
`define TEST_CLKB_HI 18
`define TEST_CLKB_LO 7
`define DEV_WORD_HI 18
`define DEV_WORD_LO 3
`define DEV_EXP_HI 22
`define DEV_EXP_LO 19
`define SET_SEL 23
`define DEV_DUAL 24
`define DEV_FSK 25
`define DEV_IRQ_HI 27
`define DEV_IRQ_LO 26
`define DEV_PARA 28
`define DEV_EXT 29
`define STEP_HI 22
`define STEP_LO 3
`define DLY_HI 14
`define DLY_LO 3
`define DLY_START 15
`define DLY_LONG 16
`define DLY_GAP 17
`define DLY_FAST 18
`define MUX_RAMP 4'hF
`define TEST_DONE 5'h03
`define TEST_RB 2'h2
`define TYPE_SAW 2'h0
`define TYPE_TRI 2'h1
`define TYPE_SSAW 2'h2
`define TYPE_SRAMP 2'h3
`define IRQ_OFF 2'h0
`define IRQ_STOP 2'h3
`define RB_BITS 6'h25
`define ONE_12 12'h001
`define RST_CLK 12'h001
`endif

// *** inc/ramp_pkg.sv ***
// Purpose: types of the ramp controller
// Assumes: nothing
// Notes: divider value is 12 integer bits over 25 fraction bits
package ramp_pkg;
	typedef enum {RS_IDLE, RS_START_DLY, RS_RUN, RS_WRAP, RS_GAP_DLY,
		RS_HOLD} ramp_state_t;
	typedef logic [36:0] nval_t;
endpackage

// *** inc/tick_if.sv ***
// Purpose: carrier between the ramp controller and an interval timer
// Assumes: ref_tick is one clk cycle per reference period
// Notes: tick pulses once per count_a times count_b reference periods
`timescale 1ns/1ns
interface tick_if #(parameter int W = 12);
	logic ref_tick;
	logic restart;
	logic [W-1:0] count_a;
	logic [W-1:0] count_b;
	logic tick;
	modport owner(output ref_tick, restart, count_a, count_b, input tick);
	modport timer(input ref_tick, restart, count_a, count_b, output tick);
endinterface // tick_if

// *** logic/interval_timer.sv ***
// Purpose: count a product of two dividers in reference periods
// Assumes: a zero divider counts as one
// Notes: tick is a registered one-cycle pulse
`timescale 1ns/1ns
module interval_timer #(parameter int W = 12) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// owner side
	tick_if.timer t
);
	logic [W-1:0] a_eff;
	logic [W-1:0] b_eff;
	logic [2*W-1:0] prod;
	logic [2*W-1:0] cnt_reg;
	logic tick_reg;

	assign a_eff = (t.count_a == '0) ? W'(1) : t.count_a;
	assign b_eff = (t.count_b == '0) ? W'(1) : t.count_b;
	assign prod = {{W{1'b0}}, a_eff} * {{W{1'b0}}, b_eff};
	assign t.tick = tick_reg;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_reg <= '0;
			tick_reg <= 1'b0;
		end else if (t.restart) begin
			cnt_reg <= '0;
			tick_reg <= 1'b0;
		end else if (t.ref_tick) begin
			if (cnt_reg >= prod - 1'b1) begin
				cnt_reg <= '0;
				tick_reg <= 1'b1;
			end else begin
				cnt_reg <= cnt_reg + 1'b1;
				tick_reg <= 1'b0;
			end
		end else begin
			tick_reg <= 1'b0;
		end
	end

	tick_on_ref_a: assert property (@(posedge clk) disable iff (!rst_b)
		t.tick |-> $past(t.ref_tick) && !$past(t.restart))
		else $error("interval tick without reference period");
endmodule // interval_timer

// *** test/host_model.sv ***
// Purpose: host side of the ramp controller: serial writes, reference,
//  modulation pin pulses and bit readback
// Assumes: every output changes just after a rising edge of clk
// Notes: serial clock idles low outside frames; released data is inverted
`timescale 1ns/1ns
module host_model
	import ramp_pkg::*;
(
	// clock
	input wire logic clk,
	// serial link
	output logic sck,
	output logic sdat,
	output logic load,
	// reference and modulation
	output logic ref_clk,
	output logic mod,
	// readback
	input wire logic mux_in
);
	logic [2:0] ref_cnt;

	initial begin
		sck = 1'b0;
		sdat = 1'b0;
		load = 1'b0;
		mod = 1'b0;
		ref_cnt = 3'h0;
	end

	// free running reference, eight clk per period
	always @(posedge clk) begin
		ref_cnt <= ref_cnt + 3'h1;
	end
	assign ref_clk = ref_cnt[2];

	// one word, msb first, serial clock 800 ns
	task automatic write_reg(input logic [31:0] w);
		for (int i = 31; i >= 0; i--) begin
			@(posedge clk);
			sck <= 1'b0;
			sdat <= w[i];
			repeat (4) @(posedge clk);
			sck <= 1'b1;
			repeat (3) @(posedge clk);
		end
		@(posedge clk);
		sck <= 1'b0;
		sdat <= ~w[0];
		repeat (3) @(posedge clk);
		load <= 1'b1;
		repeat (4) @(posedge clk);
		load <= 1'b0;
		repeat (4) @(posedge clk);
	endtask

	task automatic pulse_mod();
		@(posedge clk);
		mod <= 1'b1;
		repeat (8) @(posedge clk);
		mod <= 1'b0;
		repeat (8) @(posedge clk);
	endtask

	// 37 bits, msb first, one serial clock rise per further bit
	task automatic read_back(output nval_t v);
		@(negedge clk);
		v[36] = mux_in;
		for (int i = 35; i >= 0; i--) begin
			@(posedge clk);
			sck <= 1'b1;
			repeat (5) @(negedge clk);
			v[i] = mux_in;
			@(posedge clk);
			sck <= 1'b0;
			repeat (4) @(posedge clk);
		end
	endtask
endmodule // host_model

// *** test/tb_top.sv ***
// Purpose: self-checking bench for the ramp controller
// Assumes: host_model drives every pin of the serial side
// Notes: reference period is eight clk; three steps per burst on set 0
`timescale 1ns/1ns
module tb_top
	import ramp_pkg::*;
;
	localparam logic [30:0] R0_BASE = 31'h7832_4000;
	localparam nval_t BASE = {12'h064, 12'h800, 13'h0000};
	logic clk, rst_b, sck, sdat, load, ref_clk, mod, mux, fl, act;
	logic seen_fast;
	logic [1:0] mode;
	nval_t dv, rb;
	int fails, n_tests, cyc, dclk;

	ramp_ctrl dut (.clk(clk), .rst_b(rst_b), .serial_clk_pin(sck),
		.serial_data_pin(sdat), .serial_load_strobe(load),
		.phase_comparator_ref(ref_clk), .modulation_input_pin(mod),
		.multiplexed_output_pin(mux), .divider_value(dv), .fast_lock(fl),
		.ramp_active(act));
	host_model h (.clk(clk), .sck(sck), .sdat(sdat), .load(load),
		.ref_clk(ref_clk), .mod(mod), .mux_in(mux));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task automatic check(input string what, input nval_t seen, input nval_t exp);
		n_tests++;
		if (seen !== exp) begin
			fails++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// whole setup, highest index first, start bit clear
	task automatic run_cfg(input logic [1:0] typ, input logic [31:0] dev,
		input logic [31:0] dly, input logic [11:0] ca, input logic [11:0] cb,
		input logic [4:0] tmux);
		h.write_reg(dly | 32'h0000_0007);
		h.write_reg(32'h0000_001E);
		h.write_reg(dev | 32'h0000_0005);
		h.write_reg({6'h00, tmux, 2'h0, cb, 7'h04});
		h.write_reg({20'h0_0000, typ, 10'h003});
		h.write_reg({17'h0_0000, ca, 3'h2});
		h.write_reg(32'h0000_0001);
		h.write_reg({1'b0, R0_BASE});
		if (dev[28]) begin
			h.write_reg({20'h0_0000, typ, 10'h00B});
			h.write_reg({20'h0_0000, typ, 10'h003});
		end
	endtask

	task automatic start_ramp();
		h.write_reg({1'b1, R0_BASE});
	endtask

	always @(posedge clk) begin
		cyc++;
		if (fl === 1'b1)
			seen_fast = 1'b1;
		if (cyc == 60000) begin
			fails++;
			wrap_up();
		end
	end

	initial begin
		rst_b = 1'b0;
		seen_fast = 1'b0;
		repeat (20) @(posedge clk);
		rst_b <= 1'b1;
		repeat (4) @(negedge clk);
		check("reset divider", dv, 37'h0);
		check("reset active", act, 37'h0);
		check("reset pin", mux, 37'h0);
		check("reset fast lock", fl, 37'h0);
		$display("test reset done");

		run_cfg(2'h3, 32'h0008_0028, 32'h0, 12'h001, 12'h004, 5'h03);
		check("idle before start", act, 37'h0);
		start_ramp();
		@(negedge clk);
		check("running", act, 37'h1);
		repeat (300) @(negedge clk);
		check("burst end value", dv, BASE + 37'h1E);
		check("burst end active", act, 37'h0);
		check("ramp complete pin", mux, 37'h1);
		$display("test single burst done");

		for (int l = 0; l < 2; l++) begin
			dclk = l ? 480 : 160;
			run_cfg(2'h3, 32'h0008_0028, l ? 32'h0001_80A0 : 32'h0000_80A0,
				12'h003, 12'h001, 5'h00);
			start_ramp();
			repeat (dclk * 5 / 8) @(negedge clk);
			check("delayed value", dv, BASE);
			check("delayed active", act, 37'h1);
			repeat (dclk / 2 + 200) @(negedge clk);
			check("after delay", dv, BASE + 37'h1E);
		end
		$display("test delayed start done");

		run_cfg(2'h3, 32'h1000_0008, 32'h0, 12'h001, 12'h004, 5'h00);
		start_ramp();
		repeat (300) @(negedge clk);
		check("parabolic end", dv, BASE + 37'h6);
		$display("test parabolic done");

		run_cfg(2'h3, 32'h0208_0028, 32'h0, 12'h001, 12'h001, 5'h00);
		h.write_reg(32'h0280_000D);
		start_ramp();
		repeat (100) @(negedge clk);
		check("shift offset end", dv, BASE + 37'h1F);
		$display("test shift offset done");

		run_cfg(2'h1, 32'h2108_0028, 32'h0, 12'h001, 12'h001, 5'h00);
		h.write_reg(32'h0080_000E);
		h.write_reg(32'h2180_0015);
		start_ramp();
		repeat (4) h.pulse_mod();
		repeat (10) @(negedge clk);
		check("dual rate turn", dv, BASE + 37'h1C);
		h.write_reg(32'h2180_001D);
		repeat (4) h.pulse_mod();
		repeat (10) @(negedge clk);
		check("rate rewritten", dv, BASE + 37'h37);
		$display("test dual rate done");

		run_cfg(2'h3, 32'h2000_0020, 32'h0, 12'h001, 12'h001, 5'h00);
		start_ramp();
		repeat (100) @(negedge clk);
		check("no pulse no step", dv, BASE);
		h.pulse_mod();
		h.pulse_mod();
		repeat (10) @(negedge clk);
		check("two pulse steps", dv, BASE + 37'h8);
		$display("test external steps done");

		run_cfg(2'h3, 32'h0408_0028, 32'h0, 12'h001, 12'h001, 5'h02);
		start_ramp();
		repeat (200) @(negedge clk);
		h.pulse_mod();
		h.read_back(rb);
		check("readback word", rb, BASE + 37'h1E);
		h.pulse_mod();
		h.write_reg({6'h00, 5'h02, 2'h0, 12'h001, 7'h04});
		h.read_back(rb);
		check("continuous readback", rb, BASE + 37'h1E);
		$display("test readback done");

		for (int m = 0; m < 3; m++) begin
			mode = (m == 2) ? 2'h3 : m[1:0];
			run_cfg(2'h0, {4'h0, mode, 26'h008_0028}, 32'h0006_0028,
				12'h001, 12'h001, 5'h02);
			start_ramp();
			repeat (200) @(negedge clk);
			h.pulse_mod();
			check("sweep after irq", act, {36'h0, mode != 2'h3});
		end
		check("gap fast lock", {36'h0, seen_fast}, 37'h1);
		$display("test interrupt modes done");
		wrap_up();
	end
endmodule // tb_top
